/* File: rtl/cca_regs.svh */
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH

// Register byte offsets on the APB window.
`define CCA_OFS_CTRL     8'h00
`define CCA_OFS_CLEAR    8'h04
`define CCA_OFS_THRESH0  8'h08
`define CCA_OFS_THRESH1  8'h0C
`define CCA_OFS_ACCUM0   8'h10
`define CCA_OFS_ACCUM1   8'h14
`define CCA_OFS_STATUS   8'h18

// Control register fields: enable bit per port, action field per port.
`define CCA_CTRL_EN_LSB   0
`define CCA_CTRL_ACT_LSB  4
`define CCA_ACT_W         2

// Status register field positions, two bits each (one per port).
`define CCA_ST_FLAG_LSB   0
`define CCA_ST_ACTIVE_LSB 2
`define CCA_ST_PIN_LSB    4
`define CCA_ST_SW_LSB     6
`define CCA_ST_SLEEP_LSB  8

// Reset values.
`define CCA_RST_ACTION    2'h1
`define CCA_RST_ENABLE    1'h0
`define CCA_RST_THRESH    32'hFFFFFFFF

`endif

/* File: rtl/cca_pkg.sv */
package cca_pkg;

    // Action taken when a port reaches its charge cap.
    typedef enum logic [1:0] {
        CCA_ACT_REPORT = 2'h0,
        CCA_ACT_DISC   = 2'h1,
        CCA_ACT_SLEEP  = 2'h2,
        CCA_ACT_IGNORE = 2'h3
    } cca_action_t;

    // Power state of one port as seen by the cap logic.
    typedef enum logic [1:0] {
        CCA_PS_IDLE,
        CCA_PS_ACTIVE,
        CCA_PS_SLEEP
    } cca_pstate_t;

    // Registered per-port outputs towards the rest of the switch.
    typedef struct packed {
        logic switch_closed;
        logic monitor_en;
        logic alert_drive;
        logic state_active;
        logic state_sleep;
    } cca_port_out_t;

endpackage : cca_pkg

/* File: rtl/cca_accum.sv */
`timescale 1ns/1ps
`default_nettype none

// Per-port charge accumulator with threshold compare.
module cca_accum
    import cca_pkg::*;
#(
    parameter int ACC_W    = 32,
    parameter int SAMPLE_W = 16
) (
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                clk_en,
    input  wire logic                run,
    input  wire logic                clear,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic [ACC_W-1:0]    threshold,
    output var  logic [ACC_W-1:0]    acc_reg,
    output logic                     at_threshold
);

    logic [ACC_W:0]   sum_wide;
    logic [ACC_W-1:0] acc_next;

    // Saturating sum so a long session never wraps below the threshold.
    always_comb begin
        sum_wide = {1'b0, acc_reg} + {{(ACC_W + 1 - SAMPLE_W){1'b0}}, sample};
        acc_next = sum_wide[ACC_W] ? {ACC_W{1'b1}} : sum_wide[ACC_W-1:0];
    end

    // A clear wins over a sample in the same cycle; the sample is dropped.
    always_ff @(posedge clock) begin
        if (reset) begin
            acc_reg <= '0;
        end else if (clk_en) begin
            if (clear) begin
                acc_reg <= '0;
            end else if (run && sample_valid) begin
                acc_reg <= acc_next;
            end
        end
    end

    assign at_threshold = (acc_reg >= threshold);

endmodule : cca_accum

`default_nettype wire

/* File: rtl/cca_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

`include "cca_regs.svh"

module cca_ctrl
    import cca_pkg::*;
#(
    parameter int NPORT    = 2,
    parameter int ACC_W    = 32,
    parameter int SAMPLE_W = 16
) (
    input  wire logic                           clock,
    input  wire logic                           reset,
    input  wire logic                           clk_en,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output var  logic [31:0]                    prdata,
    output logic                                pready,
    output var  logic                           pslverr,
    input  wire logic [NPORT-1:0]               port_power_request,
    input  wire logic [NPORT-1:0]               charge_valid,
    input  wire logic [NPORT-1:0][SAMPLE_W-1:0] charge_amount,
    input  wire logic [NPORT-1:0]               alert_n_in,
    output logic      [NPORT-1:0]               alert_n_out,
    output logic      [NPORT-1:0]               alert_n_oe,
    output var  cca_port_out_t [NPORT-1:0]      port_out
);

    // Software-visible settings.
    logic        [NPORT-1:0]            charge_cap_enable_reg;
    cca_action_t [NPORT-1:0]            charge_cap_action_select_reg;
    logic        [NPORT-1:0][ACC_W-1:0] thresh_reg;
    logic        [NPORT-1:0]            clear_pulse;

    // Per-port state.
    logic        [NPORT-1:0]            charge_cap_flag_reg;
    cca_pstate_t [NPORT-1:0]            pstate_reg;
    logic        [NPORT-1:0][ACC_W-1:0] acc;
    logic        [NPORT-1:0]            at_thr;
    logic        [NPORT-1:0]            cross_evt;
    logic        [NPORT-1:0]            cap_clear;

    // APB slave bookkeeping.
    logic        armed_reg;
    logic        wr_en;
    logic        rd_hit;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    // Access is accepted only in an access phase whose data was staged.
    assign pready = clk_en && penable && armed_reg;
    assign wr_en  = psel && penable && pwrite && pready;

    // Read data is staged in the setup cycle so prdata comes from a flop.
    always_ff @(posedge clock) begin
        if (reset) begin
            prdata    <= 32'h00000000;
            pslverr   <= 1'b0;
            armed_reg <= 1'b0;
        end else if (clk_en) begin
            if (psel && !penable) begin
                prdata    <= pwrite ? 32'h00000000 : rd_mux;
                pslverr   <= !rd_hit;
                armed_reg <= 1'b1;
            end else if (psel && penable && armed_reg) begin
                armed_reg <= 1'b0;
            end
        end
    end

    // Status word gathers flags, state and the sensed alert pin levels.
    always_comb begin
        status_word = 32'h00000000;
        for (int p = 0; p < NPORT; p++) begin
            status_word[`CCA_ST_FLAG_LSB + p]   = charge_cap_flag_reg[p];
            status_word[`CCA_ST_ACTIVE_LSB + p] =
                (pstate_reg[p] == CCA_PS_ACTIVE);
            status_word[`CCA_ST_PIN_LSB + p]    = alert_n_in[p];
            status_word[`CCA_ST_SW_LSB + p]     = port_out[p].switch_closed;
            status_word[`CCA_ST_SLEEP_LSB + p]  =
                (pstate_reg[p] == CCA_PS_SLEEP);
        end
    end

    // Read decode; unmapped addresses answer zero with an error.
    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (paddr)
            `CCA_OFS_CTRL: begin
                for (int p = 0; p < NPORT; p++) begin
                    rd_mux[`CCA_CTRL_EN_LSB + p] = charge_cap_enable_reg[p];
                    rd_mux[`CCA_CTRL_ACT_LSB + `CCA_ACT_W*p +: `CCA_ACT_W] =
                        charge_cap_action_select_reg[p];
                end
            end
            `CCA_OFS_CLEAR:   rd_mux = 32'h00000000;
            `CCA_OFS_THRESH0: rd_mux[ACC_W-1:0] = thresh_reg[0];
            `CCA_OFS_THRESH1: rd_mux[ACC_W-1:0] = thresh_reg[1];
            `CCA_OFS_ACCUM0:  rd_mux[ACC_W-1:0] = acc[0];
            `CCA_OFS_ACCUM1:  rd_mux[ACC_W-1:0] = acc[1];
            `CCA_OFS_STATUS:  rd_mux = status_word;
            default:          rd_hit = 1'b0;
        endcase
    end

    // Control writes; an action write touches nothing else.
    always_ff @(posedge clock) begin
        if (reset) begin
            charge_cap_enable_reg <= {NPORT{`CCA_RST_ENABLE}};
            for (int p = 0; p < NPORT; p++) begin
                charge_cap_action_select_reg[p] <=
                    cca_action_t'(`CCA_RST_ACTION);
            end
        end else if (wr_en && paddr == `CCA_OFS_CTRL) begin
            for (int p = 0; p < NPORT; p++) begin
                charge_cap_enable_reg[p] <= pwdata[`CCA_CTRL_EN_LSB + p];
                charge_cap_action_select_reg[p] <= cca_action_t'(
                    pwdata[`CCA_CTRL_ACT_LSB + `CCA_ACT_W*p +: `CCA_ACT_W]);
            end
        end
    end

    // Threshold writes.
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int p = 0; p < NPORT; p++) begin
                thresh_reg[p] <= `CCA_RST_THRESH;
            end
        end else if (wr_en) begin
            if (paddr == `CCA_OFS_THRESH0) begin
                thresh_reg[0] <= pwdata[ACC_W-1:0];
            end
            if (paddr == `CCA_OFS_THRESH1) begin
                thresh_reg[1] <= pwdata[ACC_W-1:0];
            end
        end
    end

    // The clear register is write-one, self-clearing, and reads zero.
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            clear_pulse[p] = wr_en && (paddr == `CCA_OFS_CLEAR) && pwdata[p];
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            cca_action_t   act;
            logic          cut_switch;
            cca_port_out_t out_next;

            assign act = charge_cap_action_select_reg[gp];

            // Enable low acts as a held clear, so nothing accumulates.
            assign cap_clear[gp] = clear_pulse[gp] ||
                                   !charge_cap_enable_reg[gp];

            // Charge is counted only in the Active state.
            cca_accum #(
                .ACC_W    (ACC_W),
                .SAMPLE_W (SAMPLE_W)
            ) u_accum (
                .clock        (clock),
                .reset        (reset),
                .clk_en       (clk_en),
                .run          (pstate_reg[gp] == CCA_PS_ACTIVE),
                .clear        (cap_clear[gp]),
                .sample_valid (charge_valid[gp]),
                .sample       (charge_amount[gp]),
                .threshold    (thresh_reg[gp]),
                .acc_reg      (acc[gp]),
                .at_threshold (at_thr[gp])
            );

            // A crossing counts only while enabled and Active.
            assign cross_evt[gp] = charge_cap_enable_reg[gp] &&
                                   (pstate_reg[gp] == CCA_PS_ACTIVE) &&
                                   at_thr[gp] &&
                                   !charge_cap_flag_reg[gp];

            // Flag: a crossing in the clearing cycle wins over the clear.
            always_ff @(posedge clock) begin
                if (reset) begin
                    charge_cap_flag_reg[gp] <= 1'b0;
                end else if (clk_en) begin
                    if (cross_evt[gp]) begin
                        charge_cap_flag_reg[gp] <= 1'b1;
                    end else if (cap_clear[gp]) begin
                        charge_cap_flag_reg[gp] <= 1'b0;
                    end
                end
            end

            // Power state follows the request unless the sleep action
            // holds it; clearing the flag or leaving that action
            // re-samples the request on the next edge.
            always_ff @(posedge clock) begin
                if (reset) begin
                    pstate_reg[gp] <= CCA_PS_IDLE;
                end else if (clk_en) begin
                    if (charge_cap_flag_reg[gp] && act == CCA_ACT_SLEEP) begin
                        pstate_reg[gp] <= CCA_PS_SLEEP;
                    end else if (port_power_request[gp]) begin
                        pstate_reg[gp] <= CCA_PS_ACTIVE;
                    end else begin
                        pstate_reg[gp] <= CCA_PS_IDLE;
                    end
                end
            end

            // Output decode is stateless in the action, so a new action
            // after the threshold takes effect on the next edge.
            assign cut_switch = charge_cap_flag_reg[gp] &&
                                (act == CCA_ACT_DISC ||
                                 act == CCA_ACT_SLEEP);

            always_comb begin
                out_next.switch_closed = (pstate_reg[gp] == CCA_PS_ACTIVE)
                                         && !cut_switch;
                out_next.monitor_en    = (pstate_reg[gp] != CCA_PS_SLEEP);
                out_next.alert_drive   = charge_cap_flag_reg[gp] &&
                                         (act == CCA_ACT_REPORT ||
                                          act == CCA_ACT_DISC);
                out_next.state_active  = (pstate_reg[gp] == CCA_PS_ACTIVE);
                out_next.state_sleep   = (pstate_reg[gp] == CCA_PS_SLEEP);
            end

            // Registered outputs; switch opens one edge before the Sleep
            // state shows, giving the required order; the sleep action leaves the alert released.
            always_ff @(posedge clock) begin
                if (reset) begin
                    port_out[gp] <= '0;
                end else if (clk_en) begin
                    port_out[gp] <= out_next;
                end
            end

            // Open-drain alert: only ever pulls low.
            assign alert_n_out[gp] = 1'b0;
            assign alert_n_oe[gp]  = port_out[gp].alert_drive;

            AST_CROSS_ACTIVE: assert property (@(posedge clock)
                disable iff (reset)
                $rose(charge_cap_flag_reg[gp]) |->
                    $past(pstate_reg[gp] == CCA_PS_ACTIVE))
                else $error("Cap flag rose outside Active state.");

            AST_NORMAL_BEFORE: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && !charge_cap_flag_reg[gp] &&
                 pstate_reg[gp] == CCA_PS_ACTIVE) |=>
                    port_out[gp].switch_closed)
                else $error("Switch open before threshold.");

            AST_DISC_OPEN: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && cut_switch) |=>
                    !port_out[gp].switch_closed)
                else $error("Switch closed under disconnect action.");

            AST_ALERT_ON: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && charge_cap_flag_reg[gp] &&
                 (act == CCA_ACT_REPORT || act == CCA_ACT_DISC)) |=>
                    alert_n_oe[gp])
                else $error("Alert not driven after threshold.");

            AST_ALERT_OFF: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && !charge_cap_flag_reg[gp]) |=>
                    !alert_n_oe[gp])
                else $error("Alert driven without cap flag.");

            AST_SLEEP_HOLD: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && charge_cap_flag_reg[gp] &&
                 act == CCA_ACT_SLEEP && $changed(port_power_request[gp]))
                |=> pstate_reg[gp] == CCA_PS_SLEEP)
                else $error("Request toggled state while capped asleep.");

            AST_MON_OFF: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && pstate_reg[gp] == CCA_PS_SLEEP) |=>
                    !port_out[gp].monitor_en)
                else $error("Monitoring active in Sleep.");

            // Sleep may only show once the switch has already opened.
            AST_SLEEP_ORDER: assert property (@(posedge clock)
                disable iff (reset)
                $rose(port_out[gp].state_sleep) |->
                    $past(!port_out[gp].switch_closed))
                else $error("Sleep shown before switch opened.");

            AST_CLEAR_ZERO: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && cap_clear[gp] && !cross_evt[gp]) |=>
                    (acc[gp] == '0) && !charge_cap_flag_reg[gp])
                else $error("Clear left charge or flag set.");

            AST_REQ_FOLLOW: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && !charge_cap_flag_reg[gp] &&
                 port_power_request[gp]) |=>
                    pstate_reg[gp] == CCA_PS_ACTIVE)
                else $error("Request not followed when uncapped.");

            AST_FLAG_SET: assert property (@(posedge clock)
                disable iff (reset)
                (clk_en && cross_evt[gp]) |=>
                    charge_cap_flag_reg[gp])
                else $error("Crossing did not set cap flag.");
        end
    endgenerate

endmodule : cca_ctrl

`default_nettype wire

/* File: testbench/cca_port_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Far side of both ports: the charge sampler and the pulled-up alert wires.
module cca_port_model (
    input  wire logic             clock,
    input  wire logic [1:0]       alert_n_out,
    input  wire logic [1:0]       alert_n_oe,
    output logic      [1:0]       alert_n_in,
    output logic      [1:0]       charge_valid,
    output logic      [1:0][15:0] charge_amount
);
    // The alert lines carry pull-ups, so a released pin reads high.
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            alert_n_in[p] = alert_n_oe[p] ? alert_n_out[p] : 1'b1;
        end
    end

    // Idle values at time zero.
    initial begin
        charge_valid  = 2'h0;
        charge_amount = '0;
    end

    // One-cycle strobe; the amount is inverted afterwards so stale
    // data never happens to match a real sample.
    task automatic push(input int p, input logic [15:0] a);
        @(posedge clock);
        charge_valid[p]  <= 1'b1;
        charge_amount[p] <= a;
        @(posedge clock);
        charge_valid[p]  <= 1'b0;
        charge_amount[p] <= ~a;
    endtask : push
endmodule : cca_port_model

`default_nettype wire

/* File: testbench/tb_charge_cap_action_control.sv */
`timescale 1ns/1ps
`default_nettype none

`include "cca_regs.svh"

module tb_charge_cap_action_control;
    import cca_pkg::*;

    logic                  clock;
    logic                  reset;
    logic                  clk_en;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [1:0]            req;
    logic [1:0]            cv;
    logic [1:0][15:0]      ca;
    logic [1:0]            ain;
    logic [1:0]            aout;
    logic [1:0]            aoe;
    cca_port_out_t [1:0]   po;
    logic [2:0]            obs;
    logic [31:0]           rdv;
    logic                  erv;
    int                    num_errors;
    int                    cmp_count;

    assign obs = {aoe[0], po[0].switch_closed, po[0].state_sleep};

    cca_ctrl cca_ctrl_i (
        .clock(clock), .reset(reset), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .port_power_request(req), .charge_valid(cv),
        .charge_amount(ca), .alert_n_in(ain),
        .alert_n_out(aout), .alert_n_oe(aoe), .port_out(po)
    );

    cca_port_model cca_port_model_i (
        .clock(clock), .alert_n_out(aout), .alert_n_oe(aoe),
        .alert_n_in(ain), .charge_valid(cv), .charge_amount(ca)
    );

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic print_verdict;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the rising
    // edge at which pready is sampled high, then the request is let go.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            num_errors++;
            print_verdict();
        end
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Both ports enabled, port 1 on the default action.
    task automatic wctl(input logic [1:0] a0);
        wr(`CCA_OFS_CTRL, {24'h0, 2'h1, a0, 4'h3});
    endtask : wctl

    // Every port latency in the hand-over is three edges or fewer.
    task automatic st;
        repeat (4) @(posedge clock);
        #1;
    endtask : st

    task automatic setreq(input logic [1:0] v);
        @(posedge clock);
        req <= v;
        st();
    endtask : setreq

    // Expected {alert, switch closed, sleep} once capped with request high.
    function automatic logic [2:0] ex(input logic [1:0] a);
        case (a)
            2'h0: ex = 3'b110;
            2'h1: ex = 3'b100;
            2'h2: ex = 3'b001;
            default: ex = 3'b010;
        endcase
    endfunction : ex

    task automatic t_regs;
        rd(`CCA_OFS_CTRL);
        chk(rdv, 32'h50);
        chk(32'(erv), 32'h0);
        rd(`CCA_OFS_THRESH0);
        chk(rdv, 32'hFFFFFFFF);
        wr(`CCA_OFS_ACCUM0, 32'h5);
        rd(`CCA_OFS_ACCUM0);
        chk(rdv, 32'h0);
        rd(8'h1C);
        chk(rdv, 32'h0);
        chk(32'(erv), 32'h1);
    endtask : t_regs

    task automatic t_idle;
        setreq(2'h1);
        wctl(2'h1);
        wr(`CCA_OFS_THRESH1, 32'hA);
        cca_port_model_i.push(1, 16'h7);
        rd(`CCA_OFS_ACCUM1);
        chk(rdv, 32'h0);
    endtask : t_idle

    task automatic t_disc;
        wr(`CCA_OFS_THRESH0, 32'hA);
        cca_port_model_i.push(0, 16'h5);
        wr(`CCA_OFS_CLEAR, 32'h1);
        rd(`CCA_OFS_ACCUM0);
        chk(rdv, 32'h0);
        cca_port_model_i.push(0, 16'h5);
        cca_port_model_i.push(0, 16'h4);
        wctl(2'h1);
        rd(`CCA_OFS_ACCUM0);
        chk(rdv, 32'h9);
        chk(32'(obs), 32'h2);
        cca_port_model_i.push(0, 16'h1);
        st();
        rd(`CCA_OFS_STATUS);
        chk(rdv, 32'h25);
        chk(32'({obs, po[0].monitor_en}), 32'h9);
        setreq(2'h0);
        chk(32'(po[0].state_active), 32'h0);
        setreq(2'h1);
        chk(32'({po[0].state_active, obs}), 32'hC);
        wr(`CCA_OFS_CLEAR, 32'h1);
        st();
        rd(`CCA_OFS_STATUS);
        chk(rdv, 32'h74);
        rd(`CCA_OFS_ACCUM0);
        chk(rdv, 32'h0);
        chk(32'({ain[0], obs}), 32'hA);
    endtask : t_disc

    task automatic t_sleep;
        wctl(2'h2);
        cca_port_model_i.push(0, 16'hA);
        st();
        chk(32'({obs, po[0].monitor_en}), 32'h2);
        setreq(2'h0);
        chk(32'(po[0].state_sleep), 32'h1);
        wr(`CCA_OFS_CLEAR, 32'h1);
        st();
        chk(32'({po[0].state_active, obs}), 32'h0);
        setreq(2'h1);
        chk(32'({po[0].state_active, obs}), 32'hA);
    endtask : t_sleep

    // Every ordered pair of two different actions: cap under one, then switch.
    task automatic t_change;
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
                if (i != j) begin
                    wctl(2'(i));
                    wr(`CCA_OFS_CLEAR, 32'h1);
                    st();
                    chk(32'(obs), 32'h2);
                    cca_port_model_i.push(0, 16'hA);
                    st();
                    chk(32'(obs), 32'(ex(2'(i))));
                    wctl(2'(j));
                    st();
                    chk(32'(obs), 32'(ex(2'(j))));
                end
            end
        end
    endtask : t_change

    task automatic t_enable;
        wctl(2'h1);
        wr(`CCA_OFS_CLEAR, 32'h1);
        cca_port_model_i.push(0, 16'h3);
        wr(`CCA_OFS_CTRL, 32'h52);
        rd(`CCA_OFS_ACCUM0);
        chk(rdv, 32'h0);
        cca_port_model_i.push(0, 16'h3);
        rd(`CCA_OFS_ACCUM0);
        chk(rdv, 32'h0);
    endtask : t_enable

    // Clock enable low freezes port 1: no sample, no state change.
    task automatic t_freeze;
        setreq(2'h3);
        chk(32'(po[1].switch_closed), 32'h1);
        @(posedge clock);
        clk_en <= 1'b0;
        cca_port_model_i.push(1, 16'h4);
        setreq(2'h1);
        chk(32'(po[1].state_active), 32'h1);
        @(posedge clock);
        clk_en <= 1'b1;
        st();
        chk(32'(po[1].state_active), 32'h0);
        rd(`CCA_OFS_ACCUM1);
        chk(rdv, 32'h0);
    endtask : t_freeze

    // Reset for twelve cycles, then the scenarios in order.
    initial begin
        num_errors = 0;
        cmp_count  = 0;
        reset      = 1'b1;
        clk_en     = 1'b1;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        req        = 2'h0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        t_regs();
        t_idle();
        t_disc();
        t_sleep();
        t_change();
        t_enable();
        t_freeze();
        print_verdict();
    end
endmodule : tb_charge_cap_action_control

`default_nettype wire
